// file: pdp_packer.sv
// Per-channel interface register set for process data discovery and packing.
// Assumes a link engine that moves payload to and from the remote unit and
// answers each request with LINK_DONE; all inputs synchronous to CLK_SYS.
`timescale 1ns/1ps
module pdp_packer (
  input wire logic CLK_SYS,
  input wire logic SYS_RST,
  input wire logic [7:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [31:0] REG_RDATA,
  input wire logic START_DONE,
  input wire pdp_pkg::pdp_start_info_s START_INFO,
  output logic LINK_REQ,
  output logic [95:0] LINK_OUT_DATA,
  output logic [31:0] LINK_CS_REQ,
  input wire logic LINK_DONE,
  input wire logic LINK_ERR,
  input wire pdp_pkg::pdp_link_in_s LINK_IN,
  output logic [7:0] FIELD_OUT_A,
  output logic [7:0] FIELD_OUT_B,
  output logic NO_DISCOVERY
);
  import pdp_pkg::*;

  // Host-side registers
  logic [15:0] command_r; // Command word, cleared on completion
  logic data_fail_r; // Channel failure bit of the data word
  logic [31:0] cs_out_r; // Control/status as written (opcode, address)
  logic [31:0] cs_in_r; // Control/status as read back
  logic [2:0][31:0] out_word_r; // Outgoing interface words
  logic [2:0][31:0] in_word_r; // Incoming interface words
  logic no_disc_r; // Remote unit reports no contents table
  logic started_r; // A start has completed since the last stop all
  logic [31:0] rdata_r; // Read data, valid one cycle after REG_RD

  // Link-side output registers
  logic [95:0] link_out_r; // Payload sent with the transfer
  logic [31:0] link_cs_r; // Control/status sent with the transfer
  logic [7:0] field_a_r; // First terminal block outputs
  logic [7:0] field_b_r; // Second terminal block outputs

  // Sequencer wires
  logic seq_req; // One-cycle request to the link
  logic seq_finish; // One-cycle end of transfer
  logic seq_fail; // Transfer ended in error or timeout
  logic seq_busy; // Transfer in progress

  // Address decode
  logic hit_command; // Access to the command word
  logic hit_data; // Access to the data word
  logic hit_cs; // Access to the control/status word
  logic hit_info; // Access to the info word
  logic [1:0] word_idx; // Interface word index for word hits
  logic hit_word; // Access to one of the interface words

  assign hit_command = (REG_ADDR == PDP_OFS_COMMAND);
  assign hit_data = (REG_ADDR == PDP_OFS_DATA);
  assign hit_cs = (REG_ADDR == PDP_OFS_CS);
  assign hit_info = (REG_ADDR == PDP_OFS_INFO);
  assign hit_word = (REG_ADDR == PDP_OFS_WORD0) || (REG_ADDR == PDP_OFS_WORD1)
    || (REG_ADDR == PDP_OFS_WORD2);
  assign word_idx = (REG_ADDR == PDP_OFS_WORD0) ? 2'd0
    : (REG_ADDR == PDP_OFS_WORD1) ? 2'd1 : 2'd2;

  // Command decode on a write to the command word
  logic cmd_wr; // Host writes the command word
  logic is_transfer; // Written command is a transfer command
  logic is_stop_all; // Written command is stop all
  logic is_stop; // Written command is any stop
  logic xfer_go; // Transfer with this channel selected, link idle
  logic xfer_none; // Transfer with this channel not selected

  assign cmd_wr = REG_WR && hit_command;
  assign is_transfer = (REG_WDATA[15:8] == PDP_CMD_TRANSFER);
  assign is_stop_all = (REG_WDATA[15:0] == PDP_CMD_STOP_ALL);
  assign is_stop = (REG_WDATA[11:8] == PDP_CMD_STOP_HI) && (REG_WDATA[15:12] == 4'h0);
  assign xfer_go = cmd_wr && is_transfer && REG_WDATA[0] && !seq_busy;
  assign xfer_none = cmd_wr && is_transfer && !REG_WDATA[0];

  // Remote read opcode check on the control/status word
  logic cs_is_read; // Top byte holds a read opcode
  assign cs_is_read = (cs_out_r[31:24] >= PDP_OP_READ_FIRST)
    && (cs_out_r[31:24] <= PDP_OP_READ_LAST);

  // Incoming payload mapped onto three words
  logic [2:0][31:0] link_words; // Incoming payload as words
  pdp_lane_map u_lane_in (
    .payload(LINK_IN.payload),
    .words(link_words)
  );

  // Outgoing words flattened back into payload order
  logic [95:0] out_payload; // Outgoing words as one payload
  assign out_payload = {out_word_r[2], out_word_r[1], out_word_r[0]};

  // Transfer sequencer
  pdp_xfer_seq u_seq (
    .clk(CLK_SYS),
    .rst(SYS_RST),
    .go(xfer_go),
    .link_done(LINK_DONE),
    .link_err(LINK_ERR),
    .req_r(seq_req),
    .finish_r(seq_finish),
    .fail_r(seq_fail),
    .busy(seq_busy)
  );

  // Read mux for the register port
  logic [31:0] rd_mux; // Selected read value
  assign rd_mux = hit_command ? {16'h0000, command_r}
    : hit_data ? {31'h0, data_fail_r}
    : hit_cs ? cs_in_r
    : hit_word ? in_word_r[word_idx]
    : hit_info ? {29'h0, started_r, seq_busy, no_disc_r}
    : 32'h0000_0000;

  // Local fault byte: link errors set, stop clears, set wins
  logic [7:0] local_flt_nxt; // Next local fault byte
  assign local_flt_nxt = (seq_finish ? LINK_IN.local_flt : 8'h00)
    | ((cmd_wr && is_stop) ? 8'h00 : cs_in_r[7:0]);

  // Command word: written by host, cleared on completion
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      command_r <= PDP_CMD_RESET;
    end else if (cmd_wr && !is_transfer) begin
      // Other commands are outside this block and complete at once
      command_r <= PDP_CMD_RESET;
    end else if (xfer_go) begin
      command_r <= REG_WDATA[15:0];
    end else if (xfer_none || seq_finish) begin
      command_r <= PDP_CMD_RESET;
    end
  end

  // Data word: failure bit of the last transfer
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      data_fail_r <= 1'b0;
    end else if (seq_finish) begin
      data_fail_r <= seq_fail;
    end else if (xfer_go) begin
      data_fail_r <= 1'b0;
    end
  end

  // Control/status as written by the host
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      cs_out_r <= PDP_WORD_RESET;
    end else if (REG_WR && hit_cs) begin
      cs_out_r <= REG_WDATA;
    end else if (seq_finish) begin
      // A remote read request is consumed by one transfer
      cs_out_r <= PDP_WORD_RESET;
    end
  end

  // Control/status as read: faults, link state, status code
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      cs_in_r <= PDP_WORD_RESET;
    end else if (seq_finish) begin
      cs_in_r <= {LINK_IN.remote_flt, LINK_IN.link_state_code,
        LINK_IN.status, local_flt_nxt};
    end else if (cmd_wr && is_stop_all) begin
      cs_in_r <= PDP_WORD_RESET;
    end else begin
      cs_in_r[7:0] <= local_flt_nxt;
    end
  end

  // Outgoing words written by the host ahead of a transfer
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      out_word_r <= '0;
    end else if (REG_WR && hit_word) begin
      out_word_r[word_idx] <= REG_WDATA;
    end
  end

  // Incoming words: setup data at start, payload after a transfer without failure
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      in_word_r <= '0;
    end else if (START_DONE) begin
      in_word_r[0] <= START_INFO.unit_number;
      in_word_r[1] <= START_INFO.unit_name;
      in_word_r[2] <= {START_INFO.global_contents_pointer,
        START_INFO.contents_table_pointer};
    end else if (seq_finish && !seq_fail) begin
      in_word_r <= link_words;
    end
  end

  // Discovery support flag and start tracking
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      no_disc_r <= 1'b0;
      started_r <= 1'b0;
    end else if (START_DONE) begin
      no_disc_r <= (START_INFO.contents_table_pointer == 16'h0000);
      started_r <= 1'b1;
    end else if (cmd_wr && is_stop_all) begin
      no_disc_r <= 1'b0;
      started_r <= 1'b0;
    end
  end

  // Payload and request word latched when the transfer is issued
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      link_out_r <= '0;
      link_cs_r <= PDP_WORD_RESET;
    end else if (xfer_go) begin
      link_out_r <= out_payload;
      link_cs_r <= cs_is_read ? cs_out_r : PDP_WORD_RESET;
    end
  end

  // Terminal block outputs follow outgoing word 0 bytes 0 and 1
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      field_a_r <= 8'h00;
      field_b_r <= 8'h00;
    end else if (xfer_go) begin
      field_a_r <= out_word_r[0][7:0];
      field_b_r <= out_word_r[0][15:8];
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      rdata_r <= 32'h0000_0000;
    end else begin
      rdata_r <= REG_RD ? rd_mux : 32'h0000_0000;
    end
  end

  // Outputs straight from flip-flops
  assign REG_RDATA = rdata_r;
  assign LINK_REQ = seq_req;
  assign LINK_OUT_DATA = link_out_r;
  assign LINK_CS_REQ = link_cs_r;
  assign FIELD_OUT_A = field_a_r;
  assign FIELD_OUT_B = field_b_r;
  assign NO_DISCOVERY = no_disc_r;

endmodule // pdp_packer

// file: pdp_pkg.sv
// Package for the process data packer: offsets, codes, counts and carriers.
// Assumes one 40 MHz system clock shared by every module that imports it.
package pdp_pkg;

  // Register offsets on the plain register port (byte addresses)
  localparam logic [7:0] PDP_OFS_COMMAND = 8'h00;
  localparam logic [7:0] PDP_OFS_DATA = 8'h04;
  localparam logic [7:0] PDP_OFS_CS = 8'h08;
  localparam logic [7:0] PDP_OFS_WORD0 = 8'h0C;
  localparam logic [7:0] PDP_OFS_WORD1 = 8'h10;
  localparam logic [7:0] PDP_OFS_WORD2 = 8'h14;
  localparam logic [7:0] PDP_OFS_INFO = 8'h18;

  // Command word codes
  localparam logic [7:0] PDP_CMD_TRANSFER = 8'h10;
  localparam logic [15:0] PDP_CMD_STOP_ALL = 16'h0800;
  localparam logic [3:0] PDP_CMD_STOP_HI = 4'h8;

  // Remote read opcodes in the top byte of the control/status word
  localparam logic [7:0] PDP_OP_READ_FIRST = 8'h44;
  localparam logic [7:0] PDP_OP_READ_LAST = 8'h47;

  // Field positions and reset values
  localparam int PDP_PTR_LSB = 0;
  localparam int PDP_BYTES = 12;
  localparam int PDP_WORDS = 3;
  localparam int PDP_PAYLOAD_BITS = 96;
  localparam logic [31:0] PDP_WORD_RESET = 32'h0000_0000;
  localparam logic [15:0] PDP_CMD_RESET = 16'h0000;

  // Transfer timeout: longest time, rounded down to whole cycles
  localparam int PDP_CLK_PERIOD_PS = 25000;
  localparam int PDP_XFER_TIMEOUT_US = 100;
  localparam int PDP_XFER_TIMEOUT_CYC = (PDP_XFER_TIMEOUT_US * 1000000) / PDP_CLK_PERIOD_PS;
  localparam logic [11:0] PDP_TIMEOUT_LAST = 12'(PDP_XFER_TIMEOUT_CYC - 1);

  // Transfer sequencer states, one-hot
  typedef enum logic [3:0] {
    PDP_ST_IDLE = 4'h1,
    PDP_ST_REQ = 4'h2,
    PDP_ST_WAIT = 4'h4,
    PDP_ST_DONE = 4'h8
  } pdp_state_e;

  // Incoming answer of one transfer from the link side
  typedef struct packed {
    logic [7:0] remote_flt;
    logic [7:0] link_state_code;
    logic [7:0] status;
    logic [7:0] local_flt;
    logic [95:0] payload;
  } pdp_link_in_s;

  // Setup information presented when a start completes
  typedef struct packed {
    logic [31:0] unit_number;
    logic [31:0] unit_name;
    logic [15:0] global_contents_pointer;
    logic [15:0] contents_table_pointer;
  } pdp_start_info_s;

endpackage

// file: pdp_lane_map.sv
// Byte lane mapper between the 96-bit payload and three 32-bit words.
// Assumes payload byte 0 is the least significant byte of the payload.
`timescale 1ns/1ps
module pdp_lane_map (
  input wire logic [95:0] payload,
  output logic [2:0][31:0] words
);
  import pdp_pkg::*;

  // Byte i lands in word i/4, lane i%4, filling low lanes first
  genvar gi;
  generate
    for (gi = 0; gi < PDP_BYTES; gi++) begin : g_lane
      assign words[gi / 4][(gi % 4) * 8 +: 8] = payload[gi * 8 +: 8];
    end
  endgenerate

endmodule // pdp_lane_map

// file: pdp_xfer_seq.sv
// Transfer sequencer: one request to the link, then wait for done or timeout.
// Assumes the link answers a request with a one-cycle done pulse.
`timescale 1ns/1ps
module pdp_xfer_seq (
  input wire logic clk,
  input wire logic rst,
  input wire logic go,
  input wire logic link_done,
  input wire logic link_err,
  output logic req_r,
  output logic finish_r,
  output logic fail_r,
  output logic busy
);
  import pdp_pkg::*;

  pdp_state_e state_r; // Current state
  pdp_state_e state_nxt; // Next state
  logic [11:0] wait_r; // Cycles spent waiting for the link
  logic timed_out; // Wait hit the timeout limit

  assign timed_out = (wait_r == PDP_TIMEOUT_LAST);
  assign busy = (state_r != PDP_ST_IDLE);

  // Next-state logic
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      PDP_ST_IDLE: begin
        if (go) begin
          state_nxt = PDP_ST_REQ;
        end
      end
      PDP_ST_REQ: begin
        state_nxt = PDP_ST_WAIT;
      end
      PDP_ST_WAIT: begin
        // Done or timeout both end the transfer
        if (link_done || timed_out) begin
          state_nxt = PDP_ST_DONE;
        end
      end
      default: begin
        state_nxt = PDP_ST_IDLE;
      end
    endcase
  end

  // State, wait counter and pulses
  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= PDP_ST_IDLE;
      wait_r <= '0;
      req_r <= 1'b0;
      finish_r <= 1'b0;
      fail_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      wait_r <= (state_r == PDP_ST_WAIT) ? wait_r + 12'h001 : 12'h000;
      req_r <= (state_nxt == PDP_ST_REQ);
      finish_r <= (state_nxt == PDP_ST_DONE);
      if (state_r == PDP_ST_WAIT && state_nxt == PDP_ST_DONE) begin
        fail_r <= link_err || !link_done;
      end
    end
  end

endmodule // pdp_xfer_seq

// file: pdp_packer_monitor.sv
// Checker for the packer: register port, transfer issue, start flags.
// Sees only the top ports; bound from the bench file.
`timescale 1ns/1ps
module pdp_packer_monitor
  import pdp_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic SYS_RST,
  input wire logic [7:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [31:0] REG_RDATA,
  input wire logic START_DONE,
  input wire pdp_pkg::pdp_start_info_s START_INFO,
  input wire logic LINK_REQ,
  input wire logic [95:0] LINK_OUT_DATA,
  input wire logic [31:0] LINK_CS_REQ,
  input wire logic LINK_DONE,
  input wire logic LINK_ERR,
  input wire pdp_pkg::pdp_link_in_s LINK_IN,
  input wire logic [7:0] FIELD_OUT_A,
  input wire logic [7:0] FIELD_OUT_B,
  input wire logic NO_DISCOVERY
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (SYS_RST);
  wire cmd_go; // Transfer command write with channel 0 selected
  wire ptr_zero; // Start reports no contents table
  assign cmd_go = REG_WR && REG_ADDR == PDP_OFS_COMMAND && REG_WDATA[15:8] == PDP_CMD_TRANSFER
    && REG_WDATA[0];
  assign ptr_zero = START_INFO.contents_table_pointer == 16'h0000;
  // Command write, then the request in the very next cycle
  sequence s_issue;
    cmd_go ##1 LINK_REQ;
  endsequence
  property p_issue; LINK_REQ |-> $past(cmd_go); endproperty
  a_issue: assert property (p_issue) else $error("request without command");
  property p_req_once; s_issue |=> !LINK_REQ [*3]; endproperty
  a_req_once: assert property (p_req_once) else $error("request repeated");
  property p_req_pulse; LINK_REQ |=> !LINK_REQ; endproperty
  a_req_pulse: assert property (p_req_pulse) else $error("request too long");
  property p_rd_idle; !REG_RD |=> REG_RDATA == 32'h0000_0000; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
  property p_field; ##0 {FIELD_OUT_B, FIELD_OUT_A} == LINK_OUT_DATA[15:0]; endproperty
  a_field: assert property (p_field) else $error("field bytes differ");
  property p_out_hold;
    $changed(LINK_OUT_DATA) && !$past(SYS_RST) |-> LINK_REQ;
  endproperty
  a_out_hold: assert property (p_out_hold) else $error("payload moved alone");
  property p_start; START_DONE |=> NO_DISCOVERY == $past(ptr_zero); endproperty
  a_start: assert property (p_start) else $error("no discovery flag wrong");
  property p_cs_op;
    LINK_CS_REQ != 32'h0 |-> LINK_CS_REQ[31:24] inside {[PDP_OP_READ_FIRST:PDP_OP_READ_LAST]};
  endproperty
  a_cs_op: assert property (p_cs_op) else $error("bad read opcode");
endmodule // pdp_packer_monitor

// file: pdp_link_model.sv
// Link partner: answers each request after a set number of cycles.
// Answer is valid in the done cycle and the next, else inverted.
`timescale 1ns/1ps
module pdp_link_model
  import pdp_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic req,
  input wire logic [7:0] dly,
  input wire logic err_sel,
  input wire pdp_pkg::pdp_link_in_s ans,
  output logic done,
  output logic err,
  output pdp_pkg::pdp_link_in_s link_in
);
  logic [7:0] cnt_r; // Cycles left to the answer
  logic done_d_r; // Second cycle of the answer window
  // Count down from each request and pulse done once
  always_ff @(posedge clk) begin
    if (rst || req) begin
      cnt_r <= rst ? 8'h00 : dly;
    end else if (cnt_r != 8'h00) begin
      cnt_r <= cnt_r - 8'h01;
    end
    done <= !rst && !req && cnt_r == 8'h01;
    done_d_r <= done;
  end
  // Error qualifies the done cycle only
  assign err = done && err_sel;
  // Status and payload of the answer
  assign link_in = (done || done_d_r) ? ans : ~ans;
endmodule // pdp_link_model

// file: pdp_packer_bench.sv
// Bench for the packer: register tasks, a link partner and checks.
// Assumes the checker and partner files compile first.
`timescale 1ns/1ps
module pdp_packer_bench;
  import pdp_pkg::*;
  logic clk, rst, wr, rd, sdone, req, ldone, lerr, nodisc, err_sel;
  logic [7:0] addr, fa, fb, dly;
  logic [31:0] wdata, rdata, csreq, v, cs_seen;
  logic [95:0] out, out_seen;
  pdp_start_info_s info;
  pdp_link_in_s lin, ans;
  int fail_count, checked, cyc, reqs, n0, ents, bad;
  logic [15:0] p, e, t;
  pdp_packer i_pdp_packer (.CLK_SYS(clk), .SYS_RST(rst), .REG_ADDR(addr), .REG_WDATA(wdata),
    .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .START_DONE(sdone), .START_INFO(info),
    .LINK_REQ(req), .LINK_OUT_DATA(out), .LINK_CS_REQ(csreq), .LINK_DONE(ldone),
    .LINK_ERR(lerr), .LINK_IN(lin), .FIELD_OUT_A(fa), .FIELD_OUT_B(fb), .NO_DISCOVERY(nodisc));
  pdp_link_model i_pdp_link_model (.clk(clk), .rst(rst), .req(req), .dly(dly),
    .err_sel(err_sel), .ans(ans), .done(ldone), .err(lerr), .link_in(lin));
  // Clock, 25 ns period
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Cycle ceiling and request count
  always @(posedge clk) begin
    cyc++;
    if (req) reqs++;
    if (cyc == 20000) begin
      fail_count++;
      finish_test;
    end
  end
  task automatic finish_test;
    $display("Checks %0d, mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [95:0] got, input logic [95:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // Start pulse, then pointer word and flag
  task automatic start(input logic [15:0] p);
    @(posedge clk);
    info <= {32'h0000_0007, 32'h4443_4241, 16'h0010, p};
    sdone <= 1'b1;
    @(posedge clk);
    sdone <= 1'b0;
    rd_reg(PDP_OFS_WORD2, v);
    chk(v, {16'h0010, p});
    chk(nodisc, p == 16'h0000);
  endtask
  // Transfer command, capture issue values, poll for the clear
  task automatic xfer;
    int n;
    wr_reg(PDP_OFS_COMMAND, 32'h0000_1001);
    #1 out_seen = out;
    cs_seen = csreq;
    v = 32'h1;
    for (n = 0; n < 300 && v !== 32'h0; n++) rd_reg(PDP_OFS_COMMAND, v);
    chk(v, 32'h0);
  endtask
  // Remote memory seen by the walker: table at 0x0200, records at 0x0300 and 0x0310
  function automatic logic [15:0] rmem(input logic [15:0] a);
    case (a)
      16'h0200: return 16'h0300;
      16'h0202: return 16'h0310;
      16'h0300: return 16'h00A0;
      16'h0310: return 16'h00B0;
      default: return 16'h0000;
    endcase
  endfunction
  // One remote read through the control/status word and a transfer
  task automatic rread(input logic [7:0] op, input logic [15:0] a, output logic [15:0] d);
    ans <= {32'h0, 80'h0, rmem(a)};
    wr_reg(PDP_OFS_CS, {op, 8'h00, a});
    xfer;
    chk(cs_seen, {op, 8'h00, a});
    rd_reg(PDP_OFS_WORD0, v);
    d = v[15:0];
  endtask
  initial begin
    {rst, wr, rd, sdone, err_sel} = 5'b10000;
    {addr, wdata, info, ans} = '0;
    dly = 8'h03;
    {fail_count, checked, cyc, reqs} = '0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd_reg(PDP_OFS_INFO, v);
    chk(v, 32'h0);
    rd_reg(8'h1C, v);
    chk(v, 32'h0);
    start(16'h0000);
    start(16'h0200);
    // Outgoing bytes 0 to 11, then a prompt good transfer
    wr_reg(PDP_OFS_WORD0, 32'h0302_0100);
    wr_reg(PDP_OFS_WORD1, 32'h0706_0504);
    wr_reg(PDP_OFS_WORD2, 32'h0B0A_0908);
    ans <= {32'h8011_2204, 96'hC1C2C3C4_B1B2B3B4_A1A2A3A4};
    xfer;
    chk(out_seen, 96'h0B0A0908_07060504_03020100);
    chk({fb, fa}, 16'h0100);
    for (int i = 0; i < 3; i++) begin
      rd_reg(8'(PDP_OFS_WORD0 + 4 * i), v);
      chk(v, ans.payload[32 * i +: 32]);
    end
    rd_reg(PDP_OFS_CS, v);
    chk(v, 32'h8011_2204);
    rd_reg(PDP_OFS_DATA, v);
    chk(v, 32'h0);
    // Slow failing transfer keeps the old words
    err_sel <= 1'b1;
    dly <= 8'd40;
    ans <= '0;
    xfer;
    rd_reg(PDP_OFS_DATA, v);
    chk(v[0], 1'b1);
    rd_reg(PDP_OFS_WORD0, v);
    chk(v, 32'hA1A2_A3A4);
    // Remote reads with every opcode
    err_sel <= 1'b0;
    dly <= 8'd1;
    for (int op = 0; op < 4; op++) begin
      ans <= {32'h0, 80'h0, 16'(16'h5A00 + op)};
      wr_reg(PDP_OFS_CS, {8'(8'h44 + op), 8'h00, 16'h1234});
      xfer;
      chk(cs_seen, {8'(8'h44 + op), 8'h00, 16'h1234});
      rd_reg(PDP_OFS_WORD0, v);
      chk(v[15:0], 16'(16'h5A00 + op));
    end
    // Table walk in two-byte steps to the zero entry, records classified
    p = 16'h0200;
    ents = 0;
    bad = 0;
    rread(8'h45, p, e);
    while (e != 16'h0000 && ents < 8) begin
      rread(8'h44, e, t);
      if (t[7:0] != 8'hA0 && t[7:0] != 8'hB0) bad++;
      ents++;
      p = p + 16'h0002;
      rread(8'h45, p, e);
    end
    chk(ents, 2);
    chk(bad, 0);
    // Command without channel 0 makes no request
    n0 = reqs;
    wr_reg(PDP_OFS_COMMAND, 32'h0000_1000);
    repeat (4) @(posedge clk);
    chk(reqs, n0);
    rd_reg(PDP_OFS_COMMAND, v);
    chk(v, 32'h0);
    // Stop all clears the no discovery flag
    start(16'h0000);
    wr_reg(PDP_OFS_COMMAND, {16'h0, PDP_CMD_STOP_ALL});
    rd_reg(PDP_OFS_INFO, v);
    chk(v[0], 1'b0);
    finish_test;
  end
endmodule // pdp_packer_bench

bind pdp_packer pdp_packer_monitor i_pdp_packer_monitor (.CLK_SYS(CLK_SYS),
  .SYS_RST(SYS_RST), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
  .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .START_DONE(START_DONE), .START_INFO(START_INFO),
  .LINK_REQ(LINK_REQ), .LINK_OUT_DATA(LINK_OUT_DATA), .LINK_CS_REQ(LINK_CS_REQ),
  .LINK_DONE(LINK_DONE), .LINK_ERR(LINK_ERR), .LINK_IN(LINK_IN), .FIELD_OUT_A(FIELD_OUT_A),
  .FIELD_OUT_B(FIELD_OUT_B), .NO_DISCOVERY(NO_DISCOVERY));
